// ==== hdl/fps_params.svh ====
// constants for the fault propagation and sync block
`ifndef FPS_PARAMS_SVH
`define FPS_PARAMS_SVH

// register byte offsets (low address byte)
`define FPS_ADDR_CTRL    8'h00
`define FPS_ADDR_PROP    8'h04
`define FPS_ADDR_TIME    8'h08
`define FPS_ADDR_STATUS  8'h0C
`define FPS_ADDR_MASK    8'h10
`define FPS_ADDR_STATE   8'h14

// control register fields
`define FPS_CTRL_ON      0
`define FPS_CTRL_F1M     1
`define FPS_CTRL_PH_LSB  2
`define FPS_CTRL_PH_MSB  5
`define FPS_CTRL_TREN    6
`define FPS_CTRL_RST     7'h40

// propagation config fields
`define FPS_PROP_PR_MSB  4
`define FPS_PROP_LT_LSB  5
`define FPS_PROP_LT_MSB  9
`define FPS_PROP_OT_CRIT 10
`define FPS_PROP_UV_CRIT 11
`define FPS_PROP_OV_EMER 12
`define FPS_PROP_RST     13'h0000

// timing register fields, both in milliseconds
`define FPS_TIME_DLY_MSB 7
`define FPS_TIME_FAL_LSB 8
`define FPS_TIME_RST     16'h0000

// fault vector and status bit positions
`define FPS_F_TR         0
`define FPS_F_OT         1
`define FPS_F_OC         2
`define FPS_F_UV         3
`define FPS_F_OV         4
`define FPS_ST_REMOTE    5
`define FPS_ST_TW        6
`define FPS_ST_PGLOW     7

// timing
`define FPS_CLK_NS       40
`define FPS_TICK_NS      1000000
`define FPS_HICCUP_MS    130
`define FPS_PWM_NS_500K  2000
`define FPS_PWM_NS_1M    1000
`define FPS_PHASE_SHIFT  4

`endif

// ==== hdl/fps_pkg.sv ====
// types shared by the fault propagation and sync block
package fps_pkg;

    typedef enum logic [2:0] {
        FPS_OFF,
        FPS_RUN,
        FPS_DELAY,
        FPS_RAMP,
        FPS_HALT
    } fps_state_t;

    typedef enum logic [1:0] {
        FPS_SEQ,
        FPS_CRIT,
        FPS_EMER
    } fps_toff_t;

endpackage : fps_pkg

// ==== hdl/fps_sync.sv ====
// two-flop synchroniser bank for pins entering the core clock domain
`timescale 1ns/100ps
`default_nettype none

module fps_sync #(
    parameter int unsigned W = 9
) (
    // clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         nrst_i,
    // pins in, synchronised copies out
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } fps_sync_t;

    fps_sync_t s_r;
    fps_sync_t s_nxt;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.meta = async_i;
        s_nxt.stab = s_r.meta;
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sync_o = s_r.stab;

endmodule : fps_sync

`default_nettype wire

// ==== hdl/fps_core.sv ====
// fault propagation, fault-line coding and sync-locked PWM start timing
// Notes on behaviour
// (R1) enabled fault makes this regulator pull its fault line low
// (R2) seeing the line fall, turn off with the reporter's turn-off type
// (R3) turn-off type rides the line's falling pattern, three codes, all sample
// (R4) fault line drive changes only on sync line falling edge
// (R5) manager supports groups of 4 to 32 sharing one fault line
// (R6) a fault propagates only if enabled in propagation config register
// (R7) manager relays turn-off code unchanged to linked groups
// (R8) manager forwards propagated faults to configured linked groups
// (R9) manager may command front-end shutdown and crowbar after group error
// (R10) undervoltage turn-off is sequenced: delay then programmed falling ramp
// (R11) non-latching fault retries every 130 ms regardless of turn-off delay
// (R12) fault kinds map to fixed turn-off classes; only tracking may be off; here OV, OT and UV classes are set in the propagation config
// (R13) switching rate per regulator is 500 kHz or 1 MHz by config
// (R14) switching actions lock to the 500 kHz sync line falling edge
// (R15) PWM start delayed from sync fall by phase in 22.5 degree steps
// (R16) sequenced ramps; critical opens both; emergency turns low side on
// (R17) latched fault stays off until 130 ms, cause gone and status cleared
// (R18) fault line is wired-AND: only pulled low or released
`timescale 1ns/100ps
`default_nettype none
`include "fps_params.svh"

module fps_core #(
    parameter int unsigned TICK_CYC = `FPS_TICK_NS / `FPS_CLK_NS
) (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    // ahb-lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // shared lines
    input  wire logic        sync_line_i,
    input  wire logic        fault_line_i,
    output logic             fault_line_o,
    output logic             fault_line_oe_o,
    // protection inputs from analog comparators
    input  wire logic        ramp_deviation_fault_i,
    input  wire logic        overheat_fault_i,
    input  wire logic        overcurrent_fault_i,
    input  wire logic        undervoltage_fault_i,
    input  wire logic        excess_voltage_error_i,
    input  wire logic        temp_warning_i,
    input  wire logic        power_good_i,
    // power stage control
    output logic             high_side_en_o,
    output logic             low_side_en_o,
    output logic             ramp_down_o,
    output logic             regulator_on_o,
    output logic             pwm_start_o,
    output logic             power_good_o,
    output logic             irq_o
);

    localparam int unsigned PER500 = `FPS_PWM_NS_500K / `FPS_CLK_NS;
    localparam int unsigned PER1M  = `FPS_PWM_NS_1M / `FPS_CLK_NS;

    typedef struct packed {
        logic [6:0]           ctrl;
        logic [12:0]          prop;
        logic [15:0]          tim;
        logic [7:0]           status;
        logic [7:0]           mask;
        logic                 a_valid;
        logic                 a_wr;
        logic [7:0]           a_addr;
        logic [31:0]          hrdata;
        logic                 hready;
        logic                 sync_prev;
        logic                 line_smp;
        logic [1:0]           rx_cnt;
        logic [1:0]           rx_bits;
        logic                 rx_done;
        logic                 tx_pend;
        logic [1:0]           tx_slot;
        fps_pkg::fps_toff_t   tx_type;
        logic                 drv_low;
        fps_pkg::fps_state_t  state;
        fps_pkg::fps_toff_t   toff;
        logic                 remote;
        logic [4:0]           lat_vec;
        logic [14:0]          ms_div;
        logic [7:0]           ms_cnt;
        logic [7:0]           hic_ms;
        logic [5:0]           ph_cnt;
        logic [4:0]           f_prev;
        logic                 tw_prev;
        logic                 pg_prev;
        logic                 pwm_start;
        logic                 pg_out;
        logic                 irq;
        logic                 hs_en;
        logic                 ls_en;
        logic                 ramp;
        logic                 reg_on;
    } fps_core_t;

    fps_core_t r_r;
    fps_core_t r_nxt;
    logic [8:0] pins_s;

    fps_sync #(
        .W (9)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .async_i    ({power_good_i, temp_warning_i, excess_voltage_error_i,
                      undervoltage_fault_i, overcurrent_fault_i,
                      overheat_fault_i, ramp_deviation_fault_i,
                      fault_line_i, sync_line_i}),
        .sync_o     (pins_s)
    );

    // phase in sixteenths of the own switching period
    function automatic logic [5:0] phase_cycles(input logic [3:0] ph,
                                                input logic [5:0] per);
        logic [9:0] prod;
        prod = 10'(ph) * 10'(per);
        return prod[9:`FPS_PHASE_SHIFT];
    endfunction : phase_cycles

    // line level in the two code slots after the fall
    function automatic logic [1:0] code_bits(input fps_pkg::fps_toff_t t);
        unique case (t)
            fps_pkg::FPS_SEQ:  return 2'b00;
            fps_pkg::FPS_CRIT: return 2'b10;
            fps_pkg::FPS_EMER: return 2'b11;
            default:           return 2'b10;
        endcase
    endfunction : code_bits

    function automatic fps_pkg::fps_toff_t code_type(input logic [1:0] b);
        if (b == 2'b00) begin
            return fps_pkg::FPS_SEQ;
        end else if (b == 2'b11) begin
            return fps_pkg::FPS_EMER;
        end else begin
            return fps_pkg::FPS_CRIT;
        end
    endfunction : code_type

    logic                sync_fall;
    logic                sync_rise;
    logic                line_s;
    logic [4:0]          fv;
    logic                ms_tick;
    logic                f_prop;
    logic                f_latch;
    logic                cause_gone;
    logic                rel_ok;
    fps_pkg::fps_toff_t  f_type;
    logic [5:0]          per;
    logic [5:0]          ph_dly;
    logic [1:0]          tx_code;
    logic [7:0]          st_set;
    logic [7:0]          st_clr;
    logic [31:0]         rd;

    always_comb begin
        r_nxt     = r_r;
        sync_fall = r_r.sync_prev & ~pins_s[0];
        sync_rise = ~r_r.sync_prev & pins_s[0];
        line_s    = pins_s[1];
        fv        = pins_s[6:2];
        fv[`FPS_F_TR] = pins_s[2] & r_r.ctrl[`FPS_CTRL_TREN]; // R12
        r_nxt.sync_prev = pins_s[0];
        st_set    = '0;
        st_clr    = '0;
        rd        = '0;

        // ---- ahb-lite slave, zero wait states
        r_nxt.hready = 1'b1;
        if (r_r.a_valid && r_r.a_wr) begin
            unique case (r_r.a_addr)
                `FPS_ADDR_CTRL:   r_nxt.ctrl = hwdata_i[6:0];
                `FPS_ADDR_PROP:   r_nxt.prop = hwdata_i[12:0]; // R6
                `FPS_ADDR_TIME:   r_nxt.tim  = hwdata_i[15:0];
                `FPS_ADDR_STATUS: st_clr     = hwdata_i[7:0];
                `FPS_ADDR_MASK:   r_nxt.mask = hwdata_i[7:0];
                default:          ;
            endcase
        end
        r_nxt.a_valid = hsel_i & htrans_i[1] & hready_i;
        r_nxt.a_wr    = hwrite_i;
        r_nxt.a_addr  = haddr_i[7:0];
        unique case (haddr_i[7:0])
            `FPS_ADDR_CTRL:   rd = {25'h000_0000, r_r.ctrl};
            `FPS_ADDR_PROP:   rd = {19'h0_0000, r_r.prop};
            `FPS_ADDR_TIME:   rd = {16'h0000, r_r.tim};
            `FPS_ADDR_STATUS: rd = {24'h00_0000, r_r.status};
            `FPS_ADDR_MASK:   rd = {24'h00_0000, r_r.mask};
            `FPS_ADDR_STATE:  rd = {16'h0000, r_r.hic_ms, r_r.drv_low,
                                    r_r.line_smp, r_r.toff, r_r.remote,
                                    r_r.state};
            default:          rd = '0;
        endcase
        if (hsel_i && htrans_i[1] && hready_i && !hwrite_i) begin
            r_nxt.hrdata = rd;
        end

        // ---- millisecond tick
        ms_tick = (r_r.ms_div == 15'(TICK_CYC - 1));
        r_nxt.ms_div = ms_tick ? '0 : r_r.ms_div + 15'h0001;

        // ---- receive: sample the line at sync rising edge
        r_nxt.rx_done = 1'b0;
        if (sync_rise) begin
            r_nxt.line_smp = line_s;
            unique case (r_r.rx_cnt)
                2'd0: begin
                    if (r_r.line_smp && !line_s && !r_r.drv_low) begin
                        r_nxt.rx_cnt = 2'd1; // R3
                    end
                end
                2'd1: begin
                    r_nxt.rx_bits[1] = line_s;
                    r_nxt.rx_cnt     = 2'd2;
                end
                default: begin
                    r_nxt.rx_bits[0] = line_s;
                    r_nxt.rx_cnt     = 2'd0;
                    r_nxt.rx_done    = 1'b1;
                end
            endcase
        end

        // ---- local fault classification, fixed priority: OV, then OC or TR, then OT, then UV
        if (fv[`FPS_F_OV]) begin
            f_type = r_r.prop[`FPS_PROP_OV_EMER] ? fps_pkg::FPS_EMER
                                                 : fps_pkg::FPS_CRIT; // R12
        end else if (fv[`FPS_F_OC] || fv[`FPS_F_TR]) begin
            f_type = fps_pkg::FPS_CRIT; // R12
        end else if (fv[`FPS_F_OT]) begin
            f_type = r_r.prop[`FPS_PROP_OT_CRIT] ? fps_pkg::FPS_CRIT
                                                 : fps_pkg::FPS_SEQ;
        end else begin
            f_type = r_r.prop[`FPS_PROP_UV_CRIT] ? fps_pkg::FPS_CRIT
                                                 : fps_pkg::FPS_SEQ; // R10
        end
        f_prop  = |(fv & r_r.prop[`FPS_PROP_PR_MSB:0]); // R6
        f_latch = |(fv & r_r.prop[`FPS_PROP_LT_MSB:`FPS_PROP_LT_LSB]);
        cause_gone = (fv == 5'h00) && (!r_r.remote || r_r.line_smp);
        rel_ok = (r_r.hic_ms >= 8'(`FPS_HICCUP_MS)) && cause_gone;

        // ---- turn-off sequencer
        if (ms_tick && r_r.hic_ms != 8'hFF) begin
            r_nxt.hic_ms = r_r.hic_ms + 8'h01;
        end
        if (ms_tick) begin
            r_nxt.ms_cnt = r_r.ms_cnt + 8'h01;
        end
        unique case (r_r.state)
            fps_pkg::FPS_OFF: begin
                if (r_r.ctrl[`FPS_CTRL_ON] && fv == 5'h00) begin
                    r_nxt.state = fps_pkg::FPS_RUN;
                end
            end
            fps_pkg::FPS_RUN: begin
                if (fv != 5'h00) begin
                    r_nxt.toff    = f_type;
                    r_nxt.remote  = 1'b0;
                    r_nxt.lat_vec = f_latch ? fv : 5'h00;
                    r_nxt.tx_pend = f_prop; // R1
                    r_nxt.tx_type = f_type;
                end else if (r_r.rx_done) begin
                    r_nxt.toff   = code_type(r_r.rx_bits); // R2
                    r_nxt.remote = 1'b1;
                    st_set[`FPS_ST_REMOTE] = 1'b1;
                end
                if (fv != 5'h00 || r_r.rx_done) begin
                    r_nxt.hic_ms = '0; // R11
                    r_nxt.ms_cnt = '0;
                    if (fv != 5'h00 ? f_type == fps_pkg::FPS_SEQ
                                    : code_type(r_r.rx_bits)
                                      == fps_pkg::FPS_SEQ) begin
                        r_nxt.state = fps_pkg::FPS_DELAY; // R10
                    end else begin
                        r_nxt.state = fps_pkg::FPS_HALT; // R16
                    end
                end
            end
            fps_pkg::FPS_DELAY: begin
                if (r_r.ms_cnt >= r_r.tim[`FPS_TIME_DLY_MSB:0]) begin
                    r_nxt.state  = fps_pkg::FPS_RAMP; // R10
                    r_nxt.ms_cnt = '0;
                end
            end
            fps_pkg::FPS_RAMP: begin
                if (r_r.ms_cnt >= r_r.tim[15:`FPS_TIME_FAL_LSB]) begin
                    r_nxt.state = fps_pkg::FPS_HALT; // R16
                end
            end
            fps_pkg::FPS_HALT: begin
                if (rel_ok && r_r.lat_vec == 5'h00) begin
                    r_nxt.state   = fps_pkg::FPS_RUN; // R11
                    r_nxt.tx_pend = 1'b0;
                    r_nxt.remote  = 1'b0;
                end else if (rel_ok && (r_r.status[4:0] & r_r.lat_vec)
                                       == 5'h00) begin
                    r_nxt.state   = fps_pkg::FPS_RUN; // R17
                    r_nxt.tx_pend = 1'b0;
                    r_nxt.lat_vec = '0;
                    r_nxt.remote  = 1'b0;
                end
            end
        endcase
        // turn-on command cycling clears a latched fault
        if (!r_r.ctrl[`FPS_CTRL_ON]) begin
            r_nxt.state   = fps_pkg::FPS_OFF; // R17
            r_nxt.tx_pend = 1'b0;
            r_nxt.lat_vec = '0;
            r_nxt.remote  = 1'b0;
        end

        // ---- transmit: fall, two code slots, then steady low
        tx_code = code_bits(r_r.tx_type);
        if (sync_fall) begin
            if (!r_r.tx_pend) begin
                r_nxt.drv_low = 1'b0; // R4
                r_nxt.tx_slot = 2'd0;
            end else begin
                unique case (r_r.tx_slot)
                    2'd0: r_nxt.drv_low = 1'b1; // R1
                    2'd1: r_nxt.drv_low = ~tx_code[1]; // R3
                    2'd2: r_nxt.drv_low = ~tx_code[0]; // R3
                    default: r_nxt.drv_low = 1'b1;
                endcase
                if (r_r.tx_slot != 2'd3) begin
                    r_nxt.tx_slot = r_r.tx_slot + 2'd1;
                end
            end
        end

        // ---- power stage outputs
        r_nxt.reg_on = (r_nxt.state == fps_pkg::FPS_RUN);
        r_nxt.hs_en  = (r_nxt.state == fps_pkg::FPS_RUN)
                     || (r_nxt.state == fps_pkg::FPS_DELAY)
                     || (r_nxt.state == fps_pkg::FPS_RAMP);
        r_nxt.ls_en  = r_nxt.hs_en
                     || (r_nxt.state == fps_pkg::FPS_HALT
                         && r_nxt.toff == fps_pkg::FPS_EMER); // R16
        r_nxt.ramp   = (r_nxt.state == fps_pkg::FPS_RAMP); // R16
        r_nxt.pg_out = pins_s[8]; // R12

        // ---- pwm start at programmed phase after sync fall
        per    = r_r.ctrl[`FPS_CTRL_F1M] ? 6'(PER1M) : 6'(PER500); // R13
        ph_dly = phase_cycles(r_r.ctrl[`FPS_CTRL_PH_MSB:`FPS_CTRL_PH_LSB],
                              per);
        if (sync_fall) begin
            r_nxt.ph_cnt = '0; // R14
        end else if (r_r.ph_cnt != 6'h3F) begin
            r_nxt.ph_cnt = r_r.ph_cnt + 6'h01;
        end
        r_nxt.pwm_start = (r_r.state == fps_pkg::FPS_RUN)
                        && (r_r.ph_cnt == ph_dly
                            || (r_r.ctrl[`FPS_CTRL_F1M]
                                && r_r.ph_cnt == ph_dly + per)); // R15

        // ---- event status, set beats clear
        st_set[4:0] = st_set[4:0] | (fv & ~r_r.f_prev);
        st_set[`FPS_ST_TW]    = pins_s[7] & ~r_r.tw_prev;
        st_set[`FPS_ST_PGLOW] = ~pins_s[8] & r_r.pg_prev;
        r_nxt.f_prev  = fv;
        r_nxt.tw_prev = pins_s[7];
        r_nxt.pg_prev = pins_s[8];
        r_nxt.status  = (r_r.status & ~st_clr) | st_set;
        r_nxt.irq     = |(r_nxt.status & r_nxt.mask);
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            r_r        <= '0;
            r_r.ctrl   <= `FPS_CTRL_RST;
            r_r.prop   <= `FPS_PROP_RST;
            r_r.tim    <= `FPS_TIME_RST;
            r_r.hready <= 1'b1;
            r_r.line_smp  <= 1'b1;
            // pg_prev stays at the synchroniser's reset level: no false fall
            r_r.sync_prev <= 1'b1;
            r_r.ph_cnt    <= 6'h3F;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign hrdata_o        = r_r.hrdata;
    assign hreadyout_o     = r_r.hready;
    assign hresp_o         = 1'b0 & r_r.hready;
    assign fault_line_o    = 1'b0 & r_r.drv_low; // R18
    assign fault_line_oe_o = r_r.drv_low; // R18
    assign high_side_en_o  = r_r.hs_en;
    assign low_side_en_o   = r_r.ls_en;
    assign ramp_down_o     = r_r.ramp;
    assign regulator_on_o  = r_r.reg_on;
    assign pwm_start_o     = r_r.pwm_start;
    assign power_good_o    = r_r.pg_out;
    assign irq_o           = r_r.irq;

endmodule : fps_core

`default_nettype wire

// ==== sim/fps_core_sva.sv ====
// concurrent checks on the ports of the fault propagation core
`timescale 1ns/100ps
`default_nettype none
module fps_core_sva #(
    parameter int unsigned TICK_CYC = 25000
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // lines and pins in
    input wire logic sync_line_i,
    input wire logic fault_line_i,
    input wire logic overcurrent_fault_i,
    input wire logic temp_warning_i,
    input wire logic power_good_i,
    // outputs watched
    input wire logic fault_line_o,
    input wire logic fault_line_oe_o,
    input wire logic high_side_en_o,
    input wire logic low_side_en_o,
    input wire logic ramp_down_o,
    input wire logic regulator_on_o,
    input wire logic pwm_start_o,
    input wire logic power_good_o
);
    logic       sync_d_r   = 1'b1;
    logic [3:0] fall_cnt_r = 4'hf;
    logic [2:0] up_cnt_r   = 3'h0;
    // raw pin edge, so the bound also covers the design's synchroniser
    always_ff @(posedge core_clk_i) begin
        sync_d_r <= sync_line_i;
        fall_cnt_r <= (sync_d_r && !sync_line_i) ? 4'h0 :
                      fall_cnt_r + {3'h0, fall_cnt_r != 4'hf};
        up_cnt_r <= !nrst_i ? 3'h0 : up_cnt_r + {2'h0, up_cnt_r != 3'h7};
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    line_only_low_a: assert property (fault_line_o == 1'b0)
        else $error("fault line driven high");
    drive_on_sync_a: assert property (
        $changed(fault_line_oe_o) |-> fall_cnt_r <= 4'h6)
        else $error("fault line drive moved off a sync fall");
    crit_stop_a: assert property (
        $rose(overcurrent_fault_i) && regulator_on_o |->
        ##[1:6] !high_side_en_o && !low_side_en_o)
        else $error("overcurrent did not open both switches");
    pwm_pulse_a: assert property (pwm_start_o |=> !pwm_start_o)
        else $error("pwm start longer than a cycle");
    pg_follow_a: assert property (
        up_cnt_r == 3'h7 |-> power_good_o == $past(power_good_i, 3))
        else $error("power good pin does not follow its input");
    remote_off_a: assert property (
        $fell(fault_line_i) && regulator_on_o && !fault_line_oe_o |->
        ##[1:48] !regulator_on_o)
        else $error("regulator ignored a falling fault line");
    ramp_not_run_a: assert property (ramp_down_o |-> !regulator_on_o)
        else $error("ramp down while running");
    drive_off_a: assert property (
        $rose(fault_line_oe_o) |-> !regulator_on_o)
        else $error("fault line pulled while running");
    warn_stays_a: assert property (
        $rose(temp_warning_i) && regulator_on_o |=> regulator_on_o [*8])
        else $error("temperature warning turned the regulator off");
    cover property ($rose(fault_line_oe_o));
    cover property ($rose(ramp_down_o));
    cover property (low_side_en_o && !high_side_en_o);
endmodule : fps_core_sva
bind fps_core fps_core_sva #(.TICK_CYC(TICK_CYC)) i_fps_core_sva (
    .core_clk_i, .nrst_i, .sync_line_i, .fault_line_i, .overcurrent_fault_i,
    .temp_warning_i, .power_good_i, .fault_line_o, .fault_line_oe_o,
    .high_side_en_o, .low_side_en_o, .ramp_down_o, .regulator_on_o,
    .pwm_start_o, .power_good_o);
`default_nettype wire

// ==== sim/fps_mgr.sv ====
// power manager model: free-running sync line and coded fault line pull
`timescale 1ns/100ps
`default_nettype none
module fps_mgr (
    // shared lines
    output logic            sync_o,
    output logic            oe_o,
    // front end shutdown and crowbar command
    output logic            fe_off_o,
    // bench control: send a code, levels of the two code slots
    input  wire logic       send_i,
    input  wire logic [1:0] lv_i
);
    int slot = 0;
    // odd start offset keeps sync edges away from core clock edges
    initial begin
        sync_o = 1'b1;
        oe_o = 1'b0;
        fe_off_o = 1'b0;
        #7;
        forever #160 sync_o = ~sync_o;
    end
    // only pulls or lets go; the pull-up gives the high level
    always @(negedge sync_o) begin
        case (send_i ? slot : 4)
            0, 3:    oe_o <= 1'b1;
            1:       oe_o <= !lv_i[1];
            2:       oe_o <= !lv_i[0];
            default: oe_o <= 1'b0;
        endcase
        slot <= send_i ? (slot < 3 ? slot + 1 : 3) : 0;
        // group fault held low: shut the front end and fire the crowbar
        fe_off_o <= send_i && slot == 3;
    end
endmodule : fps_mgr
`default_nettype wire

// ==== sim/fps_core_test.sv ====
// self-checking bench for the fault propagation core
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module fps_core_test;
    localparam int unsigned TICK = 20;
    logic        clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, q;
    logic [1:0]  htrans = 2'b00, lv = 2'b00;
    logic        send = 1'b0, oc = 1'b0, uv = 1'b0, tw = 1'b0, pg = 1'b1;
    wire         hready, sync, m_oe, oe, hs, ls, ramp, on, irq, hresp, fe;
    wire  [31:0] hrdata;
    wire         fline = !(oe || m_oe);
    int          err_total = 0, n_tests = 0;
    fps_core #(.TICK_CYC(TICK)) i_fps_core (
        .core_clk_i(clk), .nrst_i(nrst), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .sync_line_i(sync),
        .fault_line_i(fline), .fault_line_o(), .fault_line_oe_o(oe),
        .ramp_deviation_fault_i(1'b0), .overheat_fault_i(1'b0),
        .overcurrent_fault_i(oc), .undervoltage_fault_i(uv),
        .excess_voltage_error_i(1'b0), .temp_warning_i(tw),
        .power_good_i(pg), .high_side_en_o(hs), .low_side_en_o(ls),
        .ramp_down_o(ramp), .regulator_on_o(on), .pwm_start_o(),
        .power_good_o(), .irq_o(irq));
    fps_mgr i_fps_mgr (.sync_o(sync), .oe_o(m_oe), .fe_off_o(fe),
        .send_i(send), .lv_i(lv));
    always #20 clk = ~clk;
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask : xfer
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        `CHK(q, e)
    endtask : rd
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        #2_000_000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        logic [7:0] ad [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
        logic [2:0] s = 3'h0;
        int         n, rmp;
        logic       drv;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        xfer(1'b1, 8'h20, 32'h0000_00ff);
        for (int i = 0; i < 6; i++)
            rd(ad[i], i == 0 ? 32'h0000_0040 : 32'h0000_0000);
        xfer(1'b1, 8'h00, 32'h0000_0001);
        // only overcurrent propagates; undervoltage stays local
        xfer(1'b1, 8'h04, 32'h0000_0004);
        xfer(1'b1, 8'h08, 32'h0000_0102);
        xfer(1'b1, 8'h10, 32'h0000_0004);
        rd(8'h00, 32'h0000_0001);
        wait (on === 1'b1);
        @(posedge clk);
        oc <= 1'b1;
        @(posedge oe);
        repeat (3) begin
            @(posedge sync);
            s = {s[1:0], fline};
        end
        `CHK(s, 3'b010)
        @(posedge clk);
        `CHK({hs, ls, irq, hresp}, 4'b0010)
        rd(8'h0C, 32'h0000_0004);
        xfer(1'b0, 8'h14, 32'h0000_0000);
        `CHK(q[5:0], 6'h14)
        oc <= 1'b0;
        xfer(1'b1, 8'h0C, 32'h0000_0004);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        wait (on === 1'b1);
        repeat (40) @(posedge clk);
        `CHK(oe, 1'b0)
        lv <= 2'b11;
        send <= 1'b1;
        wait (on === 1'b0);
        repeat (4) @(posedge clk);
        `CHK({hs, ls}, 2'b01)
        rd(8'h0C, 32'h0000_0020);
        `CHK(fe, 1'b1)
        send <= 1'b0;
        xfer(1'b1, 8'h0C, 32'h0000_0020);
        wait (on === 1'b1);
        @(posedge clk);
        uv <= 1'b1;
        n = 0;
        rmp = 0;
        drv = 1'b0;
        // tick phase is free running, hence the slack in the bounds
        while (n < 3000 && (n < 20 || on !== 1'b1)) begin
            @(posedge clk);
            n++;
            if (n == 10)
                uv <= 1'b0;
            if (ramp === 1'b1 && rmp == 0)
                rmp = n;
            drv |= oe;
        end
        `CHK(n >= 2580 && n <= 2640, 1'b1)
        `CHK(rmp >= 18 && rmp <= 50, 1'b1)
        `CHK({drv, irq, fe}, 3'b000)
        tw <= 1'b1;
        pg <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK(on, 1'b1)
        rd(8'h0C, 32'h0000_00c8);
        tally_and_finish();
    end
endmodule : fps_core_test
`default_nettype wire
